// ===== common/mslp_pkg.sv
package mslp_pkg;

    // ==================================================================
    // Timing
    localparam int CLK_HZ          = 100_000_000;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int MS_PER_S        = 1000;
    localparam int MS_TICK_DEFAULT = CLK_HZ / MS_PER_S;
    localparam int DEAD_TIME_NS    = 1000;
    localparam int DEAD_CYCLES     =
        (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==================================================================
    // Synchronised pin positions
    localparam int PIN_W    = 8;
    localparam int PIN_REF  = 0;
    localparam int PIN_FB   = 1;
    localparam int PIN_RUN  = 2;
    localparam int PIN_DIR  = 3;
    localparam int PIN_OCL  = 4;
    localparam int PIN_HALL = 5;

    // ==================================================================
    // Speed loop
    localparam logic [11:0] FB_TARGET_COUNT = 12'h200;
    localparam logic [11:0] LOCK_TOL        = 12'h020;
    localparam logic [11:0] COUNT_MAX       = 12'hFFF;
    localparam logic [7:0]  DUTY_START      = 8'h80;
    localparam logic [7:0]  DUTY_STEP_MAX   = 8'h10;
    localparam logic [7:0]  DUTY_STEP_MIN   = 8'h01;
    localparam logic [7:0]  DUTY_FULL       = 8'hFF;
    localparam int          DUTY_SHIFT      = 2;

    // ==================================================================
    // Lock protection timer, capacitor given in tenths of a microfarad
    // 0.33 s/uF is 33 ms per tenth; 15 ms/uF discharge is 22 units per ms
    localparam logic [13:0] TRIP_MS_PER_TENTH = 14'h0021;
    localparam logic [13:0] DISCHARGE_PER_MS  = 14'h0016;
    localparam logic [7:0]  CAP_NONE          = 8'h00;

    // ==================================================================
    // Drive
    localparam logic [2:0] BRAKE_HIGH = 3'h7;
    localparam logic [2:0] SIDE_OFF   = 3'h0;

    typedef enum logic [1:0] {
        MSLP_STOP = 2'b00,
        MSLP_RUN  = 2'b01,
        MSLP_TRIP = 2'b11
    } mslp_state_t;

    // Six-step table: returns {high[2:0], low[2:0]}; invalid codes idle
    function automatic logic [5:0] mslp_commutate(input logic [2:0] hall);
        logic [5:0] r;
        r = 6'h00;
        case (hall)
            3'h1: r = 6'h0A;
            3'h2: r = 6'h11;
            3'h3: r = 6'h09;
            3'h4: r = 6'h24;
            3'h5: r = 6'h22;
            3'h6: r = 6'h14;
            default: r = 6'h00;
        endcase
        return r;
    endfunction

endpackage

// ===== hdl/mslp_core.sv
`timescale 1ns/100ps
module mslp_core #(
    parameter int MS_TICK_CYCLES = mslp_pkg::MS_TICK_DEFAULT
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       reference_clock_input,
    input  wire logic       speed_feedback_pulse,
    input  wire logic       run_level,
    input  wire logic       direction_select,
    input  wire logic [2:0] hall_level,
    input  wire logic       current_over_limit,
    input  wire logic [7:0] lock_timer_capacitor,
    output logic            speed_lock_indicator_out,
    output logic            speed_lock_indicator_oe_n,
    output logic [2:0]      high_side_on,
    output logic [2:0]      low_side_on,
    output logic [7:0]      drive_duty,
    output logic            speed_err_valid,
    output logic            speed_accel,
    output logic [9:0]      phase_error,
    output logic            phase_err_valid,
    output logic            power_save,
    output logic            regulator_enable,
    output logic            lock_tripped
);

    localparam int TICK_W = $clog2(MS_TICK_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST =
        TICK_W'(MS_TICK_CYCLES - 1);
    localparam logic [7:0] DEAD_LOAD = 8'(mslp_pkg::DEAD_CYCLES);

    // ==================================================================
    // Pin synchronisers
    logic [mslp_pkg::PIN_W-1:0] pins;
    logic [mslp_pkg::PIN_W-1:0] s1_q;
    logic [mslp_pkg::PIN_W-1:0] s2_q;
    logic [mslp_pkg::PIN_W-1:0] s3_q;
    logic [mslp_pkg::PIN_W-1:0] f_q;
    logic [mslp_pkg::PIN_W-1:0] fp_q;

    assign pins = {hall_level, current_over_limit, direction_select,
                   run_level, speed_feedback_pulse, reference_clock_input};

    genvar gi;
    generate
        for (gi = 0; gi < mslp_pkg::PIN_W; gi++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    f_q[gi]  <= 1'b0;
                    fp_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= pins[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        f_q[gi] <= s3_q[gi];
                    end
                    fp_q[gi] <= f_q[gi];
                end
            end
        end
    endgenerate

    logic       run;
    logic       ocl;
    logic       ref_rise;
    logic       fb_rise;
    logic       dir_change;
    logic [2:0] hall;

    assign run        = f_q[mslp_pkg::PIN_RUN];
    assign ocl        = f_q[mslp_pkg::PIN_OCL];
    assign hall       = f_q[mslp_pkg::PIN_HALL +: 3];
    assign ref_rise   = f_q[mslp_pkg::PIN_REF] & ~fp_q[mslp_pkg::PIN_REF];
    assign fb_rise    = f_q[mslp_pkg::PIN_FB] & ~fp_q[mslp_pkg::PIN_FB];
    assign dir_change = f_q[mslp_pkg::PIN_DIR] ^ fp_q[mslp_pkg::PIN_DIR];

    // ==================================================================
    // Run / stop / trip state
    mslp_pkg::mslp_state_t state_q;
    logic [13:0]           charge_q;
    logic [13:0]           trip_level;
    logic                  trip_hit;

    assign trip_level = 14'(mslp_pkg::TRIP_MS_PER_TENTH
                            * {6'h00, lock_timer_capacitor});
    assign trip_hit   = (lock_timer_capacitor != mslp_pkg::CAP_NONE)
                        && (charge_q >= trip_level);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_q <= mslp_pkg::MSLP_STOP;
        end else begin
            case (state_q)
                mslp_pkg::MSLP_STOP: begin
                    if (run) begin
                        state_q <= mslp_pkg::MSLP_RUN;
                    end
                end
                mslp_pkg::MSLP_RUN: begin
                    if (!run) begin
                        state_q <= mslp_pkg::MSLP_STOP;
                    end else if (trip_hit) begin
                        state_q <= mslp_pkg::MSLP_TRIP;
                    end
                end
                mslp_pkg::MSLP_TRIP: begin
                    // Only a stop command releases the trip
                    if (!run) begin
                        state_q <= mslp_pkg::MSLP_STOP;
                    end
                end
                default: state_q <= mslp_pkg::MSLP_STOP;
            endcase
        end
    end

    // ==================================================================
    // Protection timer: millisecond tick and capacitor charge model
    logic [TICK_W-1:0] tick_q;
    logic              ms_tick;

    assign ms_tick = (tick_q == TICK_LAST);

    always_ff @(posedge core_clk) begin
        if (!rstn || ms_tick) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end

    logic lock_q;

    // A short stop leaves charge behind, so the next run trips sooner
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            charge_q <= '0;
        end else if (state_q == mslp_pkg::MSLP_RUN && lock_q) begin
            charge_q <= '0;
        end else if (ms_tick) begin
            if (state_q == mslp_pkg::MSLP_RUN && charge_q < trip_level) begin
                charge_q <= charge_q + 1'b1;
            end else if (state_q == mslp_pkg::MSLP_STOP) begin
                if (charge_q > mslp_pkg::DISCHARGE_PER_MS) begin
                    charge_q <= charge_q - mslp_pkg::DISCHARGE_PER_MS;
                end else begin
                    charge_q <= '0;
                end
            end
        end
    end

    // ==================================================================
    // Speed measurement over every other feedback cycle
    logic        measuring_q;
    logic [11:0] ref_cnt_q;
    logic [11:0] err_mag;
    logic        in_band;
    logic        slow;
    logic        meas_done;
    logic        active;

    assign active    = (state_q != mslp_pkg::MSLP_STOP);
    assign slow      = (ref_cnt_q > mslp_pkg::FB_TARGET_COUNT);
    assign err_mag   = slow ? ref_cnt_q - mslp_pkg::FB_TARGET_COUNT
                            : mslp_pkg::FB_TARGET_COUNT - ref_cnt_q;
    assign in_band   = (err_mag <= mslp_pkg::LOCK_TOL);
    assign meas_done = active && fb_rise && measuring_q;

    always_ff @(posedge core_clk) begin
        if (!rstn || !active) begin
            measuring_q     <= 1'b0;
            ref_cnt_q       <= '0;
            lock_q          <= 1'b0;
            speed_err_valid <= 1'b0;
            speed_accel     <= 1'b0;
        end else begin
            speed_err_valid <= 1'b0;
            if (fb_rise) begin
                measuring_q <= ~measuring_q;
                if (measuring_q) begin
                    lock_q          <= in_band;
                    speed_err_valid <= 1'b1;
                    speed_accel     <= slow;
                end else begin
                    // A reference edge on the start edge belongs to the period
                    ref_cnt_q <= {11'h000, ref_rise};
                end
            end else if (measuring_q) begin
                if (ref_cnt_q == mslp_pkg::COUNT_MAX) begin
                    // Feedback has stalled: a stopped rotor is not locked
                    lock_q <= 1'b0;
                end else if (ref_rise) begin
                    ref_cnt_q <= ref_cnt_q + 1'b1;
                end
            end
        end
    end

    // ==================================================================
    // Phase comparator against reference divided by 512
    logic [8:0] div_q;

    always_ff @(posedge core_clk) begin
        if (!rstn || !active) begin
            div_q           <= '0;
            phase_error     <= '0;
            phase_err_valid <= 1'b0;
        end else begin
            phase_err_valid <= fb_rise;
            if (fb_rise) begin
                // Divider phase read as signed: negative means feedback early
                phase_error <= {div_q[8], div_q};
            end
            if (ref_rise) begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    // ==================================================================
    // Drive duty adjustment
    logic [7:0] duty_q;
    logic [7:0] step;
    logic [7:0] step_raw;

    always_comb begin
        step_raw = (err_mag >> mslp_pkg::DUTY_SHIFT)
                   > 12'(mslp_pkg::DUTY_STEP_MAX)
                   ? mslp_pkg::DUTY_STEP_MAX
                   : 8'(err_mag >> mslp_pkg::DUTY_SHIFT);
        step = (step_raw < mslp_pkg::DUTY_STEP_MIN)
               ? mslp_pkg::DUTY_STEP_MIN : step_raw;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn || !active) begin
            duty_q <= mslp_pkg::DUTY_START;
        end else if (meas_done && !in_band) begin
            if (slow) begin
                duty_q <= (duty_q > mslp_pkg::DUTY_FULL - step)
                          ? mslp_pkg::DUTY_FULL : duty_q + step;
            end else begin
                duty_q <= (duty_q < step) ? 8'h00 : duty_q - step;
            end
        end
    end

    assign drive_duty = duty_q;

    // ==================================================================
    // Changeover blanking and short-brake window
    logic [7:0] dead_q;
    logic       brake_win_q;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dead_q <= '0;
        end else if (dir_change) begin
            dead_q <= DEAD_LOAD;
        end else if (dead_q != 8'h00) begin
            dead_q <= dead_q - 1'b1;
        end
    end

    // The window lasts until speed is back in band, since reverse EMF
    // stays high for the whole deceleration through zero
    always_ff @(posedge core_clk) begin
        if (!rstn || !active) begin
            brake_win_q <= 1'b0;
        end else if (dir_change) begin
            brake_win_q <= 1'b1;
        end else if (meas_done && in_band) begin
            brake_win_q <= 1'b0;
        end
    end

    // ==================================================================
    // Output stage
    logic [7:0] pwm_q;
    logic [5:0] comm;
    logic       pwm_on;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pwm_q <= '0;
        end else begin
            pwm_q <= pwm_q + 1'b1;
        end
    end

    assign pwm_on = (pwm_q < duty_q);
    // Inverted Hall code walks the six steps the other way round
    assign comm   = mslp_pkg::mslp_commutate(
                        f_q[mslp_pkg::PIN_DIR] ? ~hall : hall);

    always_ff @(posedge core_clk) begin
        if (!rstn || !active) begin
            high_side_on <= mslp_pkg::SIDE_OFF;
            low_side_on  <= mslp_pkg::SIDE_OFF;
        end else if (dir_change || dead_q != 8'h00) begin
            high_side_on <= mslp_pkg::SIDE_OFF;
            low_side_on  <= mslp_pkg::SIDE_OFF;
        end else if (brake_win_q && ocl) begin
            high_side_on <= mslp_pkg::BRAKE_HIGH;
            low_side_on  <= mslp_pkg::SIDE_OFF;
        end else begin
            high_side_on <= comm[5:3];
            if (state_q == mslp_pkg::MSLP_RUN && pwm_on && !ocl) begin
                low_side_on <= comm[2:0];
            end else begin
                low_side_on <= mslp_pkg::SIDE_OFF;
            end
        end
    end

    // ==================================================================
    // Indicator and power state
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            speed_lock_indicator_oe_n <= 1'b1;
            power_save                <= 1'b1;
            lock_tripped              <= 1'b0;
        end else begin
            speed_lock_indicator_oe_n <= ~(lock_q && active);
            power_save   <= (state_q == mslp_pkg::MSLP_STOP);
            lock_tripped <= (state_q == mslp_pkg::MSLP_TRIP);
        end
    end

    // Open collector: only ever pulls low
    assign speed_lock_indicator_out = 1'b0;
    assign regulator_enable         = 1'b1;

endmodule

// ===== verif/mslp_motor_model.sv
`timescale 1ns/100ps
module mslp_motor_model #(
    parameter int REF_HALF = 50
) (
    input  wire logic        core_clk,
    input  wire logic        spin,
    input  wire logic [11:0] fb_period,
    output logic             reference_clock_input,
    output logic             speed_feedback_pulse
);
    // ==================================================================
    // Reference source and motor feedback
    int          div_cnt;
    logic [11:0] ref_cnt;

    // One process owns every output, so each has a single driver
    initial begin
        div_cnt = 0;
        ref_cnt = 12'h000;
        reference_clock_input = 1'h0;
        speed_feedback_pulse = 1'h0;
        // Default half period gives 1 MHz at the core clock rate
        forever begin
            @(posedge core_clk);
            div_cnt <= (div_cnt == REF_HALF - 1) ? 0 : div_cnt + 1;
            if (div_cnt == REF_HALF - 1) begin
                reference_clock_input <= ~reference_clock_input;
            end
            if (div_cnt == REF_HALF - 1 && !reference_clock_input) begin
                // A stopped motor gives no feedback edges
                ref_cnt <= (!spin || ref_cnt == fb_period - 12'h001) ?
                           12'h000 : ref_cnt + 12'h001;
                speed_feedback_pulse <= spin && ref_cnt < (fb_period >> 1);
            end
        end
    end
endmodule

// ===== verif/mslp_props.sv
`timescale 1ns/100ps
module mslp_props (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       direction_select,
    input wire logic       speed_feedback_pulse,
    input wire logic       speed_lock_indicator_out,
    input wire logic       speed_lock_indicator_oe_n,
    input wire logic [2:0] high_side_on,
    input wire logic [2:0] low_side_on,
    input wire logic [7:0] drive_duty,
    input wire logic       speed_err_valid,
    input wire logic       phase_err_valid,
    input wire logic       power_save,
    input wire logic       regulator_enable,
    input wire logic       lock_tripped
);
    // ==================================================================
    // Sequences
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_drv_off;
        (high_side_on == 3'h0 && low_side_on == 3'h0) [*8];
    endsequence

    sequence s_dir_flip;
        $changed(direction_select);
    endsequence

    // ==================================================================
    // Properties
    a_reg_stays_on: assert property (regulator_enable == 1'h1)
        else $error("regulator enable dropped");
    a_lock_pin_low: assert property (speed_lock_indicator_out == 1'h0)
        else $error("lock pin data not low");
    a_lock_by_measure: assert property (
        $fell(speed_lock_indicator_oe_n) |-> $past(speed_err_valid))
        else $error("lock without a measurement");
    // Stop entry reloads the duty in the same cycle that power save shows
    a_duty_at_measure: assert property (
        $changed(drive_duty) && !power_save && !$past(power_save)
        |-> (speed_err_valid || $past(speed_err_valid)) or ##1 power_save)
        else $error("duty moved outside a measurement");
    a_trip_low_off: assert property (
        lock_tripped |-> low_side_on == 3'h0)
        else $error("low side on while tripped");
    a_trip_until_stop: assert property (
        $fell(lock_tripped) |-> ##[0:2] power_save)
        else $error("trip cleared without stop");
    a_stop_clears_trip: assert property (
        power_save |-> !lock_tripped)
        else $error("trip held in stop");
    a_dir_blank_gap: assert property (
        s_dir_flip |-> ##[1:6] s_drv_off ##50 s_drv_off)
        else $error("drivers on during changeover");
    a_brake_low_off: assert property (
        high_side_on == 3'h7 |-> low_side_on == 3'h0)
        else $error("low side on during short brake");
    a_phase_per_edge: assert property (
        $rose(speed_feedback_pulse) && !power_save
        |-> ##[1:8] phase_err_valid)
        else $error("no phase result for feedback edge");
    a_speed_pulse_one: assert property (
        speed_err_valid |=> !speed_err_valid)
        else $error("speed result pulse too long");
endmodule

// ===== verif/tb_motor_speed_lock_protection.sv
`timescale 1ns/100ps
module tb_motor_speed_lock_protection;
    localparam int TICK = 10;
    logic        core_clk;
    logic        rstn;
    logic        run_level;
    logic        direction_select;
    logic [2:0]  hall_level;
    logic        over_lim;
    logic [7:0]  cap;
    logic [11:0] fb_period;
    logic        ref_clk;
    logic        fb_pulse;
    logic        lock_oe_n;
    logic [2:0]  high_side_on;
    logic [2:0]  low_side_on;
    logic [7:0]  drive_duty;
    logic        speed_err_valid;
    logic        speed_accel;
    logic [9:0]  phase_err;
    logic        phase_err_valid;
    logic        power_save;
    logic        reg_en;
    logic        lock_tripped;
    int          fails;
    int          cmp_count;

    // ==================================================================
    // Design and partner
    mslp_core #(.MS_TICK_CYCLES(TICK)) dut_u (
        .core_clk                  (core_clk),
        .rstn                      (rstn),
        .reference_clock_input     (ref_clk),
        .speed_feedback_pulse      (fb_pulse),
        .run_level                 (run_level),
        .direction_select          (direction_select),
        .hall_level                (hall_level),
        .current_over_limit        (over_lim),
        .lock_timer_capacitor      (cap),
        .speed_lock_indicator_out  (),
        .speed_lock_indicator_oe_n (lock_oe_n),
        .high_side_on              (high_side_on),
        .low_side_on               (low_side_on),
        .drive_duty                (drive_duty),
        .speed_err_valid           (speed_err_valid),
        .speed_accel               (speed_accel),
        .phase_error               (phase_err),
        .phase_err_valid           (phase_err_valid),
        .power_save                (power_save),
        .regulator_enable          (reg_en),
        .lock_tripped              (lock_tripped)
    );

    // Fast reference keeps each measurement short; counts are unchanged
    mslp_motor_model #(.REF_HALF(4)) u_motor (
        .core_clk              (core_clk),
        .spin                  (run_level),
        .fb_period             (fb_period),
        .reference_clock_input (ref_clk),
        .speed_feedback_pulse  (fb_pulse)
    );

    initial core_clk = 1'h0;
    always #5 core_clk = ~core_clk;

    // ==================================================================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_meas(input int lim);
        int n;
        n = 0;
        while (speed_err_valid !== 1'h1 && n < lim) begin
            step(1);
            n++;
        end
        chk(8'(n < lim), 8'h01, "measurement timeout");
    endtask

    task automatic trip_time(output int n);
        run_level = 1'h1;
        n = 0;
        while (lock_tripped !== 1'h1 && n < 600) begin
            step(1);
            n++;
        end
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==================================================================
    // Scenarios
    task automatic t_reset();
        step(1);
        chk(8'(lock_oe_n), 8'h01, "oe_n reset");
        chk(8'(power_save), 8'h01, "stop saves power");
        chk(8'(reg_en), 8'h01, "regulator on in stop");
        chk(drive_duty, 8'h80, "duty reset");
        chk(8'(low_side_on), 8'h00, "low off");
        $display("reset test done");
    endtask

    task automatic t_lock();
        int n;
        logic [9:0] ph0;
        logic [9:0] ph1;
        fb_period = 12'h200;
        run_level = 1'h1;
        wait_meas(12000);
        step(1);
        chk(8'(lock_oe_n), 8'h00, "target speed locks");
        chk(drive_duty, 8'h80, "duty kept in band");
        chk(8'(power_save), 8'h00, "awake in run");
        n = 0;
        forever begin
            if (phase_err_valid === 1'h1) begin
                n++;
                ph0 = ph1;
                ph1 = phase_err;
            end
            if (speed_err_valid === 1'h1 || n > 8) break;
            step(1);
        end
        chk(8'(n), 8'h02, "phase pulses per result");
        // At exactly the target rate the divider phase repeats
        chk(8'(ph0 == ph1), 8'h01, "phase steady at target");
        $display("lock test done");
    endtask

    task automatic t_band(input logic [11:0] p, input logic acc,
                          input logic [7:0] duty);
        run_level = 1'h0;
        step(20);
        fb_period = p;
        run_level = 1'h1;
        wait_meas(10000);
        chk(8'(speed_accel), 8'(acc), "speed error sign");
        step(2);
        chk(drive_duty, duty, "duty step");
        chk(8'(lock_oe_n), 8'h01, "out of band unlocks");
        $display("band test done");
    endtask

    task automatic t_trip();
        int n;
        run_level = 1'h0;
        step(700);
        cap = 8'h01;
        fb_period = 12'h2BC;
        trip_time(n);
        chk(8'(n >= 310 && n <= 360), 8'h01, "trip period");
        step(200);
        chk(8'(low_side_on), 8'h00, "low off tripped");
        chk(8'(lock_tripped), 8'h01, "trip held in run");
        run_level = 1'h0;
        step(10);
        chk(8'(lock_tripped), 8'h00, "stop clears trip");
        trip_time(n);
        chk(8'(n < 300), 8'h01, "short stop shortens");
        run_level = 1'h0;
        cap = 8'h00;
        step(700);
        $display("trip test done");
    endtask

    task automatic t_dir();
        logic [2:0] fwd;
        fb_period = 12'h200;
        run_level = 1'h1;
        step(30);
        fwd = high_side_on;
        chk(8'(fwd != 3'h0), 8'h01, "forward drive");
        direction_select = 1'h1;
        step(10);
        chk(8'({high_side_on, low_side_on}), 8'h00, "dead early");
        step(80);
        chk(8'({high_side_on, low_side_on}), 8'h00, "dead late");
        step(30);
        chk(8'(high_side_on != fwd && high_side_on != 3'h0), 8'h01,
            "reversed drive");
        over_lim = 1'h1;
        step(8);
        chk(8'({high_side_on, low_side_on}), 8'h38, "short brake");
        over_lim = 1'h0;
        direction_select = 1'h0;
        step(120);
        run_level = 1'h0;
        $display("direction test done");
    endtask

    // ==================================================================
    // Main sequence and watchdog
    initial begin
        fails = 0;
        cmp_count = 0;
        rstn = 1'h0;
        run_level = 1'h0;
        direction_select = 1'h0;
        hall_level = 3'h1;
        over_lim = 1'h0;
        cap = 8'h00;
        fb_period = 12'h200;
        step(5);
        rstn = 1'h1;
        t_reset();
        t_lock();
        t_band(12'h232, 1'h1, 8'h8C);
        t_band(12'h1CE, 1'h0, 8'h74);
        t_trip();
        t_dir();
        complete_run();
    end

    initial begin
        repeat (70000) @(posedge core_clk);
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule

bind mslp_core mslp_props u_props (
    .core_clk                  (core_clk),
    .rstn                      (rstn),
    .direction_select          (direction_select),
    .speed_feedback_pulse      (speed_feedback_pulse),
    .speed_lock_indicator_out  (speed_lock_indicator_out),
    .speed_lock_indicator_oe_n (speed_lock_indicator_oe_n),
    .high_side_on              (high_side_on),
    .low_side_on               (low_side_on),
    .drive_duty                (drive_duty),
    .speed_err_valid           (speed_err_valid),
    .phase_err_valid           (phase_err_valid),
    .power_save                (power_save),
    .regulator_enable          (regulator_enable),
    .lock_tripped              (lock_tripped)
);
